// File: design/rx_bp_consts.svh
// constants for the receive backplane parity and offset block
// assumes: included by bare name from the design files of this block
`ifndef RX_BP_CONSTS_SVH
`define RX_BP_CONSTS_SVH

// register offsets on the 8-bit processor port
`define RBP_ADDR_PARITY_CFG 8'h32
`define RBP_ADDR_BYTE_OFFSET 8'h33
`define RBP_ADDR_BIT_OFFSET 8'h34

// reset values
`define RBP_RESET_PARITY_CFG 8'h00
`define RBP_RESET_BYTE_OFFSET 7'h00
`define RBP_RESET_BIT_OFFSET 4'h0

// parity configuration field positions
`define RBP_ODD_SELECT_BIT 7
`define RBP_INSERT_ENABLE_BIT 6
`define RBP_FORCE_BIT 5
`define RBP_LEVEL_BIT 4
`define RBP_EXTEND_BIT 3
`define RBP_RESERVED_BIT 1
`define RBP_MUX_OUTPUT_BIT 0

// bit offset field positions
`define RBP_BIT_OFFSET_ENABLE_BIT 3

// first bit edge count bases
`define RBP_EDGE_BASE_SAME 6'h04
`define RBP_EDGE_BASE_DIFF 6'h03

// frame lengths in bits per backplane rate
`define RBP_FRAME_BITS_T1 11'h0c1
`define RBP_FRAME_BITS_E1 11'h100
`define RBP_FRAME_BITS_HMVIP 11'h400

// clock period of clock_i in ns
`define RBP_CLOCK_PERIOD_NS 100

`endif

// File: design/rx_bp_pkg.sv
// types shared by the receive backplane parity and offset block
// assumes: compiled before every design file that names it
package rx_bp_pkg;

  // frame alignment states, one-hot
  typedef enum logic [2:0] {
    ST_HUNT = 3'h1,   // no frame pulse seen yet
    ST_OFFSET = 3'h2, // counting edges after the frame pulse
    ST_STREAM = 3'h4  // bits flowing out
  } align_state_t;

  // backplane rate code
  typedef logic [1:0] rate_t;

endpackage

// File: design/rx_bp_regs.sv
// register file of the receive backplane parity and offset block
// assumes: an 8-bit processor port with one-cycle read and write strobes
`include "rx_bp_consts.svh"

module rx_bp_regs (
  input wire logic clock_i,              // 10 MHz clock
  input wire logic reset_i,              // async reset, high
  input wire logic ce_i,                 // clock enable
  input wire logic cpu_cs_i,             // chip select
  input wire logic cpu_wr_i,             // write strobe
  input wire logic cpu_rd_i,             // read strobe
  input wire logic [7:0] cpu_addr_i,     // register address
  input wire logic [7:0] cpu_wdata_i,    // write data
  output logic [7:0] cpu_rdata_o,        // registered read data
  output logic [7:0] parity_cfg_o,       // parity configuration
  output logic [6:0] byte_offset_o,      // byte offset field
  output logic [3:0] bit_offset_o        // bit offset enable and value
);

  // address decode
  wire sel_parity = cpu_cs_i && (cpu_addr_i == `RBP_ADDR_PARITY_CFG);
  wire sel_byte = cpu_cs_i && (cpu_addr_i == `RBP_ADDR_BYTE_OFFSET);
  wire sel_bit = cpu_cs_i && (cpu_addr_i == `RBP_ADDR_BIT_OFFSET);

  // unused bit 2 of the parity register reads zero
  wire [7:0] parity_wmask = 8'hfb;

  // read mux, unmapped addresses read zero
  wire [7:0] rdata_mux = sel_parity ? parity_cfg_o :
                         sel_byte ? {1'b0, byte_offset_o} :
                         sel_bit ? {4'h0, bit_offset_o} : 8'h00;

  // register writes
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      parity_cfg_o <= `RBP_RESET_PARITY_CFG;
      byte_offset_o <= `RBP_RESET_BYTE_OFFSET;
      bit_offset_o <= `RBP_RESET_BIT_OFFSET;
    end else if (ce_i && cpu_wr_i) begin
      if (sel_parity) parity_cfg_o <= cpu_wdata_i & parity_wmask;
      if (sel_byte) byte_offset_o <= cpu_wdata_i[6:0];
      if (sel_bit) bit_offset_o <= cpu_wdata_i[3:0];
    end
  end

  // read data held until the next read
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_rdata_o <= 8'h00;
    end else if (ce_i && cpu_rd_i) begin
      cpu_rdata_o <= rdata_mux;
    end
  end

endmodule

// File: design/rx_bp_two_entry_buffer.sv
// two-entry buffer between the framer path and the backplane shifter
// assumes: both sides on clock_i; ready is registered so it is safe as a port
module rx_bp_two_entry_buffer #(
  parameter int WIDTH = 2 // pcm and signaling bit
) (
  input wire logic clock_i,               // 10 MHz clock
  input wire logic reset_i,               // async reset, high
  input wire logic ce_i,                  // clock enable
  input wire logic in_valid_i,            // filling side valid
  output logic in_ready_o,                // filling side ready, registered
  input wire logic [WIDTH-1:0] in_data_i, // filling side data
  output logic out_valid_o,               // draining side valid
  input wire logic out_ready_i,           // draining side ready
  output logic [WIDTH-1:0] out_data_o     // draining side data
);

  logic [WIDTH-1:0] mem [0:1]; // storage, not reset
  logic wr_ptr_reg;            // write slot
  logic rd_ptr_reg;            // read slot
  logic [1:0] count_reg;       // words held

  wire push = in_valid_i && in_ready_o;
  wire pop = out_ready_i && out_valid_o;
  wire [1:0] count_next = count_reg + {1'b0, push} - {1'b0, pop};

  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o = mem[rd_ptr_reg];

  // storage writes need no reset
  always_ff @(posedge clock_i) begin
    if (ce_i && push) mem[wr_ptr_reg] <= in_data_i;
  end

  // pointers, fill count and registered ready
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      in_ready_o <= 1'b1;
    end else if (ce_i) begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_next;
      in_ready_o <= (count_next != 2'h2);
    end
  end

endmodule

// File: design/rx_backplane_parity_offset.sv
// receive backplane parity insertion and frame offset alignment
// assumes: backplane clock and frame pulse are synchronous inputs sampled on clock_i,
// and the backplane clock runs well below half of clock_i
`include "rx_bp_consts.svh"

module rx_backplane_parity_offset (
  input wire logic clock_i,                  // 10 MHz clock
  input wire logic reset_i,                  // async reset, high
  input wire logic ce_i,                     // clock enable, freezes all state
  input wire logic cpu_cs_i,                 // register chip select
  input wire logic cpu_wr_i,                 // register write strobe
  input wire logic cpu_rd_i,                 // register read strobe
  input wire logic [7:0] cpu_addr_i,         // register address
  input wire logic [7:0] cpu_wdata_i,        // register write data
  output logic [7:0] cpu_rdata_o,            // register read data
  input wire rx_bp_pkg::rate_t rate_select_i, // backplane rate code
  input wire logic map_first24_i,            // first 24 timeslots mapping
  input wire logic fractional_mode_i,        // fractional nx64 operation
  input wire logic clock_multiple_select_i,  // backplane clock at 2x
  input wire logic frame_edge_select_i,      // frame pulse on rising edge
  input wire logic data_edge_select_i,       // data updated on rising edge
  input wire logic multiframe_pulse_i,       // frame pulse marks multiframe
  input wire logic rx_backplane_clock_i,     // backplane clock level
  input wire logic rx_backplane_frame_pulse_i, // backplane frame pulse
  input wire logic line_valid_i,             // framer path bit valid
  output logic line_ready_o,                 // framer path may send
  input wire logic line_pcm_i,               // framer path pcm bit
  input wire logic line_signaling_i,         // framer path signaling bit
  output logic rx_backplane_pcm_o,           // backplane pcm stream
  output logic rx_backplane_signaling_o,     // backplane signaling stream
  output logic frame_aligned_o,              // stream running after a pulse
  output logic underrun_o                    // bit sent with buffer empty
);

  // frame length from the rate code, reserved rate treated as 2.048
  function automatic logic [10:0] frame_bits_f(input rx_bp_pkg::rate_t rate);
    logic [10:0] bits;
    bits = `RBP_FRAME_BITS_E1;
    if (rate == 2'h0) bits = `RBP_FRAME_BITS_T1;
    if (rate == 2'h3) bits = `RBP_FRAME_BITS_HMVIP;
    return bits;
  endfunction

  // register file
  logic [7:0] parity_cfg;  // parity configuration
  logic [6:0] byte_offset; // byte offset field
  logic [3:0] bit_offset;  // bit offset enable and value

  rx_bp_regs u_regs (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .cpu_cs_i(cpu_cs_i),
    .cpu_wr_i(cpu_wr_i),
    .cpu_rd_i(cpu_rd_i),
    .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i),
    .cpu_rdata_o(cpu_rdata_o),
    .parity_cfg_o(parity_cfg),
    .byte_offset_o(byte_offset),
    .bit_offset_o(bit_offset)
  );

  // configuration fields
  wire parity_odd_select = parity_cfg[`RBP_ODD_SELECT_BIT];
  wire parity_insert_enable = parity_cfg[`RBP_INSERT_ENABLE_BIT];
  wire first_bit_force = parity_cfg[`RBP_FORCE_BIT];
  wire first_bit_level = parity_cfg[`RBP_LEVEL_BIT];
  wire parity_span_extend = parity_cfg[`RBP_EXTEND_BIT];
  wire bit_offset_enable = bit_offset[`RBP_BIT_OFFSET_ENABLE_BIT];
  wire [2:0] bit_offset_value = bit_offset[2:0];

  // parity is dropped in the unsupported mappings
  wire parity_allowed = !fractional_mode_i &&
                        !((rate_select_i != 2'h0) && map_first24_i);
  wire insert_on = parity_insert_enable && parity_allowed;

  // edge detection of the backplane clock
  logic clk_prev_reg; // last sampled clock level
  wire rise = rx_backplane_clock_i && !clk_prev_reg;
  wire fall = !rx_backplane_clock_i && clk_prev_reg;
  wire any_edge = rise || fall;
  wire data_tick = data_edge_select_i ? rise : fall;
  wire frame_tick = frame_edge_select_i ? rise : fall;
  wire fp_seen = frame_tick && rx_backplane_frame_pulse_i;

  // edges per bit: two at 1x, four at 2x
  wire edges_same = (frame_edge_select_i == data_edge_select_i);
  wire [1:0] last_phase = clock_multiple_select_i ? 2'h3 : 2'h1;

  // first bit edge count
  wire [5:0] edge_base = edges_same ? `RBP_EDGE_BASE_SAME : `RBP_EDGE_BASE_DIFF;
  wire [5:0] edge_step_1x = {2'h0, bit_offset_value, 1'b0};
  wire [5:0] edge_step_2x = {1'b0, bit_offset_value, 2'h0};
  wire [5:0] edge_step = !bit_offset_enable ? 6'h00 :
                         (clock_multiple_select_i ? edge_step_2x : edge_step_1x);
  wire [5:0] first_bit_edge_count = edge_base + edge_step;

  // byte offset converted to edges, eight bits per byte
  wire [13:0] byte_edges = clock_multiple_select_i ? {2'h0, byte_offset, 5'h00} :
                                                     {3'h0, byte_offset, 4'h0};
  wire [13:0] raw_target = byte_edges + {8'h00, first_bit_edge_count};

  // longest offset: a frame less one bit, or less two with a multiframe pulse, frame pulse on the falling edge and data on the rising edge
  wire [10:0] frame_bits = frame_bits_f(rate_select_i);
  wire short_limit = !frame_edge_select_i && data_edge_select_i && multiframe_pulse_i;
  wire [10:0] limit_bits = frame_bits - (short_limit ? 11'h002 : 11'h001);
  wire [13:0] limit_edges = (clock_multiple_select_i ? {1'b0, limit_bits, 2'h0} :
                                                      {2'h0, limit_bits, 1'b0}) -
                            {13'h0000, !edges_same};
  wire [13:0] edge_target = (raw_target > limit_edges) ? limit_edges : raw_target;

  // alignment state
  rx_bp_pkg::align_state_t state_reg;  // alignment state
  rx_bp_pkg::align_state_t state_next; // next alignment state
  logic [13:0] edge_cnt_reg;           // edges since the frame pulse
  logic [1:0] phase_reg;               // edge within the current bit
  logic [10:0] bit_idx_reg;            // bit position within the frame
  logic par_pcm_reg;                   // pcm parity accumulator
  logic par_sig_reg;                   // signaling parity accumulator

  wire in_offset = (state_reg == rx_bp_pkg::ST_OFFSET);
  wire in_stream = (state_reg == rx_bp_pkg::ST_STREAM);
  wire [13:0] edge_cnt_inc = edge_cnt_reg + 14'h0001;
  wire offset_done = in_offset && any_edge && (edge_cnt_inc == edge_target);
  wire bit_done = in_stream && any_edge && (phase_reg == last_phase);
  // a fresh frame pulse wins over a bit that would go out on the same edge
  wire emit = !fp_seen && (offset_done || bit_done);
  wire first = in_offset || (bit_idx_reg == frame_bits - 11'h001);
  wire [10:0] bit_idx_next = first ? 11'h000 : bit_idx_reg + 11'h001;

  // buffered line bits, ones when the buffer runs dry
  logic buf_valid;       // buffer holds a bit pair
  logic [1:0] buf_data;  // pcm in bit 1, signaling in bit 0
  wire pcm_line = buf_valid ? buf_data[1] : 1'b1;
  wire sig_line = buf_valid ? buf_data[0] : 1'b1;

  rx_bp_two_entry_buffer #(
    .WIDTH(2)
  ) u_buffer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .in_valid_i(line_valid_i),
    .in_ready_o(line_ready_o),
    .in_data_i({line_pcm_i, line_signaling_i}),
    .out_valid_o(buf_valid),
    .out_ready_i(emit),
    .out_data_o(buf_data)
  );

  // even parity is one on an odd count of ones, odd parity inverts it
  wire parity_pcm = par_pcm_reg ^ parity_odd_select;
  wire parity_sig = par_sig_reg ^ parity_odd_select;

  // first bit selection: parity, else forced level (pcm only), else line
  wire first_pcm = insert_on ? parity_pcm :
                   (first_bit_force ? first_bit_level : pcm_line);
  wire first_sig = insert_on ? parity_sig : sig_line;
  wire pcm_out = first ? first_pcm : pcm_line;
  wire sig_out = first ? first_sig : sig_line;

  // accumulators restart at the frame start, with the parity bit only when extended
  wire par_pcm_next = first ? (parity_span_extend && pcm_out) : (par_pcm_reg ^ pcm_out);
  wire par_sig_next = first ? (parity_span_extend && sig_out) : (par_sig_reg ^ sig_out);

  // state transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rx_bp_pkg::ST_HUNT: begin
        if (fp_seen) state_next = rx_bp_pkg::ST_OFFSET;
      end
      rx_bp_pkg::ST_OFFSET: begin
        if (fp_seen) state_next = rx_bp_pkg::ST_OFFSET;
        else if (offset_done) state_next = rx_bp_pkg::ST_STREAM;
      end
      rx_bp_pkg::ST_STREAM: begin
        if (fp_seen) state_next = rx_bp_pkg::ST_OFFSET; // realign on every pulse
      end
      default: begin
        state_next = rx_bp_pkg::ST_HUNT; // illegal code recovers
      end
    endcase
  end

  // clock sampling and state
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      clk_prev_reg <= 1'b0;
      state_reg <= rx_bp_pkg::ST_HUNT;
    end else if (ce_i) begin
      clk_prev_reg <= rx_backplane_clock_i;
      state_reg <= state_next;
    end
  end

  // edge counter from the frame pulse and phase within a bit
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      edge_cnt_reg <= 14'h0000;
      phase_reg <= 2'h0;
    end else if (ce_i) begin
      if (fp_seen) edge_cnt_reg <= 14'h0000;
      else if (in_offset && any_edge) edge_cnt_reg <= edge_cnt_inc;
      if (emit) phase_reg <= 2'h0;
      else if (in_stream && any_edge) phase_reg <= phase_reg + 2'h1;
    end
  end

  // bit position and parity accumulators advance with each bit
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bit_idx_reg <= 11'h000;
      par_pcm_reg <= 1'b0;
      par_sig_reg <= 1'b0;
    end else if (ce_i && emit) begin
      bit_idx_reg <= bit_idx_next;
      par_pcm_reg <= par_pcm_next;
      par_sig_reg <= par_sig_next;
    end
  end

  // output flip-flops, pcm and signaling updated only on the selected data edge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rx_backplane_pcm_o <= 1'b1;
      rx_backplane_signaling_o <= 1'b1;
      frame_aligned_o <= 1'b0;
      underrun_o <= 1'b0;
    end else if (ce_i) begin
      if (emit) rx_backplane_pcm_o <= pcm_out;
      if (emit) rx_backplane_signaling_o <= sig_out;
      frame_aligned_o <= (state_next == rx_bp_pkg::ST_STREAM);
      underrun_o <= emit && !buf_valid;
    end
  end

  // checks
  wire bit_pair = emit && ce_i;

  property p_pcm_parity;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && first && insert_on |=> rx_backplane_pcm_o == $past(parity_pcm);
  endproperty
  a_pcm_parity: assert property (p_pcm_parity) else $error("pcm parity bit wrong");

  property p_sig_parity;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && first && insert_on |=> rx_backplane_signaling_o == $past(parity_sig);
  endproperty
  a_sig_parity: assert property (p_sig_parity) else $error("signaling parity bit wrong");

  property p_force_level;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && first && !insert_on && first_bit_force |=> rx_backplane_pcm_o == $past(first_bit_level);
  endproperty
  a_force_level: assert property (p_force_level) else $error("forced first bit wrong");

  property p_unsupported_pass;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && first && fractional_mode_i && !first_bit_force |=> rx_backplane_pcm_o == $past(pcm_line);
  endproperty
  a_unsupported_pass: assert property (p_unsupported_pass) else $error("parity in fractional mode");

  property p_restart;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && first && !parity_span_extend |=> !par_pcm_reg && !par_sig_reg;
  endproperty
  a_restart: assert property (p_restart) else $error("accumulator not restarted");

  property p_extend;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && first && parity_span_extend |=> par_pcm_reg == rx_backplane_pcm_o;
  endproperty
  a_extend: assert property (p_extend) else $error("parity bit not in span");

  property p_no_bit_offset;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && in_offset && !bit_offset_enable && byte_offset == 7'h00 |->
        edge_cnt_inc == (edges_same ? 14'h0004 : 14'h0003);
  endproperty
  a_no_bit_offset: assert property (p_no_bit_offset) else $error("offset used while disabled");

  property p_count_1x;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && in_offset && bit_offset_enable && !clock_multiple_select_i && byte_offset == 7'h00 |->
        edge_cnt_inc == 14'h0004 + 14'h0002 * bit_offset_value - (edges_same ? 14'h0000 : 14'h0001);
  endproperty
  a_count_1x: assert property (p_count_1x) else $error("1x edge count wrong");

  property p_count_2x;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && in_offset && bit_offset_enable && clock_multiple_select_i && byte_offset == 7'h00 |->
        edge_cnt_inc == 14'h0004 + 14'h0004 * bit_offset_value - (edges_same ? 14'h0000 : 14'h0001);
  endproperty
  a_count_2x: assert property (p_count_2x) else $error("2x edge count wrong");

  property p_byte_offset;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair && in_offset && !bit_offset_enable && !clock_multiple_select_i && edges_same &&
        byte_offset < 7'h08 |-> edge_cnt_inc == 14'h0004 + 14'h0010 * byte_offset;
  endproperty
  a_byte_offset: assert property (p_byte_offset) else $error("byte offset delay wrong");

  property p_data_edge;
    @(posedge clock_i) disable iff (reset_i)
      bit_pair |-> data_tick;
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("bit left on wrong edge");

  property p_limit;
    @(posedge clock_i) disable iff (reset_i)
      in_offset |-> edge_cnt_reg < limit_edges;
  endproperty
  a_limit: assert property (p_limit) else $error("offset beyond frame limit");

  property p_cov_insert;
    @(posedge clock_i) disable iff (reset_i) bit_pair && first && insert_on;
  endproperty
  c_cov_insert: cover property (p_cov_insert);

  property p_cov_force;
    @(posedge clock_i) disable iff (reset_i) bit_pair && first && !insert_on && first_bit_force;
  endproperty
  c_cov_force: cover property (p_cov_force);

  property p_cov_wrap;
    @(posedge clock_i) disable iff (reset_i) bit_pair && first && in_stream;
  endproperty
  c_cov_wrap: cover property (p_cov_wrap);

endmodule

// File: bench/bp_system_model.sv
// system-side backplane model: clock and frame pulse, 193-bit frames
// assumes: clock_i at 10 MHz; run_i starts the backplane clock from low
module bp_system_model (
  input wire logic clock_i,  // 10 MHz clock
  input wire logic reset_i,  // async reset, high
  input wire logic run_i,    // start the backplane
  output logic bp_clock_o,   // backplane clock, 8 cycles a bit
  output logic frame_pulse_o // high across the rising edge of bit 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase_reg; // place inside one bit
  logic [7:0] bit_reg;   // bit position in the frame
  // clock stands still while idle, so no stray edge reaches the block
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      phase_reg <= 3'h0;
      bit_reg <= 8'h00;
    end else if (run_i) begin
      phase_reg <= phase_reg + 3'h1;
      if (phase_reg == 3'h7)
        bit_reg <= (bit_reg == 8'hc0) ? 8'h00 : bit_reg + 8'h01;
    end
  end
  assign bp_clock_o = phase_reg[2];
  assign frame_pulse_o = run_i && (bit_reg == 8'h00); // one pulse a frame
endmodule

// File: bench/test_rx_backplane_parity_offset.sv
// bench: register access, buffer fill, first-bit value and alignment delay
// assumes: partner model gives one backplane edge every 4 cycles
module test_rx_backplane_parity_offset;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0, reset_i = 1'b1, cs = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lat;
  logic frac = 1'b0, map = 1'b0, run = 1'b0, bpclk, fp, ready, pcm, sig, aligned;
  logic fe = 1'b1, de = 1'b1, lvalid = 1'b1, under;
  logic [1:0] rate = 2'h0;
  int fails = 0, n_tests = 0, wc;
  // cfg, byte, bit reg, {frac, rate0, map}, {pcm, sig}, extra cycles; last row has data on the falling edge
  logic [36:0] rows [12] = '{{8'h20, 8'h00, 8'h00, 3'h0, 2'h1, 8'h00}, {8'h30, 8'h00, 8'h00, 3'h0, 2'h3, 8'h00},
    {8'h00, 8'h00, 8'h00, 3'h0, 2'h3, 8'h00}, {8'h70, 8'h00, 8'h00, 3'h0, 2'h0, 8'h00},
    {8'hf0, 8'h00, 8'h00, 3'h0, 2'h3, 8'h00}, {8'h70, 8'h00, 8'h00, 3'h4, 2'h3, 8'h00},
    {8'h70, 8'h00, 8'h00, 3'h3, 2'h3, 8'h00}, {8'h70, 8'h00, 8'h00, 3'h2, 2'h0, 8'h00},
    {8'h20, 8'h01, 8'h00, 3'h0, 2'h1, 8'h40}, {8'h20, 8'h00, 8'h01, 3'h0, 2'h1, 8'h00},
    {8'h20, 8'h00, 8'h0b, 3'h0, 2'h1, 8'h18}, {8'h20, 8'h00, 8'h00, 3'h0, 2'h1, 8'hfc}};
  logic [7:0] masks [4] = '{8'hf9, 8'h79, 8'h09, 8'h00}; // readback of 8'hf9, reserved bit kept low
  always #50 clock_i = ~clock_i;
  bp_system_model partner (.clock_i(clock_i), .reset_i(reset_i), .run_i(run), .bp_clock_o(bpclk),
    .frame_pulse_o(fp));
  // framer side offers ones while valid; frame edge rising, 1x clock
  rx_backplane_parity_offset DUT (.clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1), .cpu_cs_i(cs),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .rate_select_i(rate), .map_first24_i(map), .fractional_mode_i(frac), .clock_multiple_select_i(1'b0),
    .frame_edge_select_i(fe), .data_edge_select_i(de), .multiframe_pulse_i(1'b0),
    .rx_backplane_clock_i(bpclk), .rx_backplane_frame_pulse_i(fp), .line_valid_i(lvalid),
    .line_ready_o(ready), .line_pcm_i(1'b1), .line_signaling_i(1'b1), .rx_backplane_pcm_o(pcm),
    .rx_backplane_signaling_o(sig), .frame_aligned_o(aligned), .underrun_o(under));
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one access: strobe for one cycle, read data looked at after it lands
  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {cs, wr, rd, addr, wdata} <= {1'b1, w, !w, a, d};
    @(posedge clock_i);
    {cs, wr, rd} <= 3'h0;
    @(negedge clock_i);
    if (!w)
      check(rdata, d);
  endtask
  // bounded wait for the first frame bit, counting cycles from run
  task automatic wait_aligned();
    int c;
    c = 0;
    while (aligned !== 1'b1 && c < 2000) begin
      @(negedge clock_i);
      c++;
    end
    if (c >= 2000) begin
      fails++;
      $display("MISMATCH at %0t: no alignment", $time);
      test_done();
    end
    lat = c[7:0];
  endtask
  initial begin
    for (int i = 0; i < 12; i++) begin
      @(posedge clock_i);
      {reset_i, run, lvalid} <= 3'h5;
      repeat (16) @(posedge clock_i);
      {frac, rate, map} <= {rows[i][12], 1'b0, rows[i][11:10]};
      de <= (i != 11); // last row: frame and data edges differ
      reset_i <= 1'b0;
      for (int k = 0; k < 4 && i == 0; k++) begin
        reg_acc(1'b0, 8'h32 + k[7:0], 8'h00);
        reg_acc(1'b1, 8'h32 + k[7:0], 8'hf9);
        reg_acc(1'b0, 8'h32 + k[7:0], masks[k]);
      end
      reg_acc(1'b1, 8'h32, rows[i][36:29]);
      reg_acc(1'b1, 8'h33, rows[i][28:21]);
      reg_acc(1'b1, 8'h34, rows[i][20:13]);
      check({7'h00, ready}, 8'h00); // two words held, no stream yet
      @(posedge clock_i);
      run <= 1'b1;
      @(negedge clock_i);
      wait_aligned();
      // pulse edge seen 5 cycles after run, then 4 cycles an edge: 21 cycles for 4 edges
      check(lat, 8'h15 + rows[i][7:0]);
      check({7'h00, pcm}, {7'h00, rows[i][9]});
      check({7'h00, sig}, {7'h00, rows[i][8]});
      if (i == 11) begin
        @(posedge clock_i);
        lvalid <= 1'b0; // framer stops: two held words drain, then ones go out
        wc = 0;
        while (under !== 1'b1 && wc < 40) begin
          @(negedge clock_i);
          wc++;
        end
        check({6'h00, under, pcm}, 8'h03);
      end
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule
